// ---- rtl/svd_consts.vh ----
// constants for the supply voltage detect controller: register map, fields, timing
// assumes inclusion by the design files only; no logic here
`ifndef SVD_CONSTS_VH
`define SVD_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SVD_OFF_CONTROL 12'h000
`define SVD_OFF_STATUS 12'h004
`define SVD_OFF_MASK 12'h008
`define SVD_OFF_INFO 12'h00C
// ----------------------------------------
// control register fields
// ----------------------------------------
`define SVD_BIT_ENABLE 15
`define SVD_BIT_IDLE_STOP 13
`define SVD_BIT_DIRECTION 7
`define SVD_BIT_BG_STABLE 6
`define SVD_BIT_REF_STABLE 5
`define SVD_CTRL_WMASK 16'hA08F
`define SVD_CTRL_RESET 16'h0000
`define SVD_LEVEL_EXTERNAL 4'hF
// ----------------------------------------
// status and mask bits
// ----------------------------------------
`define SVD_EV_TRIP 0
`define SVD_EV_REF_READY 1
`define SVD_EV_WIDTH 2
// ----------------------------------------
// settle times in ns at 100 MHz
// ----------------------------------------
`define SVD_CLK_NS 10
`define SVD_BG_SETTLE_NS 2000
`define SVD_REF_SETTLE_NS 5000
`define SVD_BG_CYCLES ((`SVD_BG_SETTLE_NS + `SVD_CLK_NS - 1) / `SVD_CLK_NS)
`define SVD_REF_CYCLES ((`SVD_REF_SETTLE_NS + `SVD_CLK_NS - 1) / `SVD_CLK_NS)
`endif

// ---- rtl/svd_ctrl.v ----
// supply voltage detect controller: APB registers, settle tracking, trip events
// assumes analog comparator outputs arrive asynchronously and are synchronised here
//
// Notes on behaviour
// - trip crossing in chosen direction sets flag
// - enable bit powers detector on or off
// - idle stop bit halts detector in idle
// - direction one rising, zero falling trip
// - band gap stable bit reflects settling
// - no flag until reference is stable
// - level code selects trip point or pin
// - unimplemented control bits read zero
`include "svd_consts.vh"
module svd_ctrl #(
  parameter BG_CYCLES = `SVD_BG_CYCLES,
  parameter REF_CYCLES = `SVD_REF_CYCLES,
  parameter [15:0] INFO_ID = 16'h5A01 // arbitrary identification value
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire cpu_idle,
  input wire cmp_above,
  input wire cmp_below,
  output wire detector_power,
  output wire [3:0] trip_level_select,
  output wire external_sense_select,
  output wire irq
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [15:0] control_reg;
  reg [`SVD_EV_WIDTH-1:0] status_reg;
  reg [`SVD_EV_WIDTH-1:0] status_next;
  reg [`SVD_EV_WIDTH-1:0] mask_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg slverr_reg;
  reg above_prev_reg;
  reg below_prev_reg;
  reg ref_prev_reg;
  wire [1:0] cmp_sync;
  wire above_s;
  wire below_s;
  wire wr_access;
  wire rd_access;
  wire addr_ok;
  wire running;
  wire bg_ok;
  wire ref_ok;
  wire trip_now;
  wire trip_event;
  wire ref_event;
  wire [15:0] control_view;

  // decode of mapped offsets
  function addr_mapped;
    input [11:0] a;
    begin
      addr_mapped = (a == `SVD_OFF_CONTROL) || (a == `SVD_OFF_STATUS) ||
                    (a == `SVD_OFF_MASK) || (a == `SVD_OFF_INFO);
    end
  endfunction

  // ----------------------------------------
  // apb access
  // ----------------------------------------
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && !penable && !pwrite;
  assign addr_ok = addr_mapped(paddr);
  assign pready = 1'b1; // zero wait states
  assign pslverr = slverr_reg && psel && penable;
  assign prdata = rdata_reg;

  // ----------------------------------------
  // detector activity and analog inputs
  // ----------------------------------------
  assign running = control_reg[`SVD_BIT_ENABLE] &&
                   !(control_reg[`SVD_BIT_IDLE_STOP] && cpu_idle);
  assign detector_power = running;
  assign trip_level_select = control_reg[3:0];
  assign external_sense_select = (control_reg[3:0] == `SVD_LEVEL_EXTERNAL);

  svd_sync #(
    .WIDTH(2)
  ) u_cmp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({cmp_above, cmp_below}),
    .sync_out(cmp_sync)
  );
  assign above_s = cmp_sync[1];
  assign below_s = cmp_sync[0];

  // band gap settle timer
  svd_settle #(
    .CYCLES(BG_CYCLES),
    .CW(16)
  ) u_bg_settle (
    .pclk(pclk),
    .presetn(presetn),
    .run(running),
    .done(bg_ok)
  );

  // reference settle timer, starts once band gap settled
  svd_settle #(
    .CYCLES(REF_CYCLES),
    .CW(16)
  ) u_ref_settle (
    .pclk(pclk),
    .presetn(presetn),
    .run(bg_ok),
    .done(ref_ok)
  );

  // ----------------------------------------
  // trip detection
  // ----------------------------------------
  assign trip_now = control_reg[`SVD_BIT_DIRECTION] ? above_s : below_s;
  // event on the edge into the trip condition, only when stable and running
  assign trip_event = running && ref_ok && trip_now &&
                      !(control_reg[`SVD_BIT_DIRECTION] ? above_prev_reg : below_prev_reg);
  assign ref_event = ref_ok && !ref_prev_reg;

  // history of comparator levels, cleared while idle so a held trip fires on start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      above_prev_reg <= 1'b0;
      below_prev_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      above_prev_reg <= (running && ref_ok) ? above_s : 1'b0;
      below_prev_reg <= (running && ref_ok) ? below_s : 1'b0;
      ref_prev_reg <= ref_ok;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // control register, writable bits only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= `SVD_CTRL_RESET;
    end else if (wr_access && paddr == `SVD_OFF_CONTROL) begin
      control_reg <= pwdata[15:0] & `SVD_CTRL_WMASK;
    end
  end

  // sticky status: set wins over write-one-to-clear
  always @* begin
    status_next = status_reg;
    if (wr_access && paddr == `SVD_OFF_STATUS) begin
      status_next = status_reg & ~pwdata[`SVD_EV_WIDTH-1:0];
    end
    if (trip_event) begin
      status_next[`SVD_EV_TRIP] = 1'b1;
    end
    if (ref_event) begin
      status_next[`SVD_EV_REF_READY] = 1'b1;
    end
  end

  // status and mask storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= {`SVD_EV_WIDTH{1'b0}};
      mask_reg <= {`SVD_EV_WIDTH{1'b0}};
    end else begin
      status_reg <= status_next;
      if (wr_access && paddr == `SVD_OFF_MASK) begin
        mask_reg <= pwdata[`SVD_EV_WIDTH-1:0];
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------
  // read path
  // ----------------------------------------
  assign control_view = {control_reg[15:8], control_reg[7], bg_ok, ref_ok,
                         1'b0, control_reg[3:0]};

  // read data chosen at setup, held through access
  always @* begin
    rdata_next = 32'h00000000;
    case (paddr)
      `SVD_OFF_CONTROL: rdata_next = {16'h0000, control_view};
      `SVD_OFF_STATUS: rdata_next = {30'h00000000, status_reg};
      `SVD_OFF_MASK: rdata_next = {30'h00000000, mask_reg};
      `SVD_OFF_INFO: rdata_next = {16'h0000, INFO_ID};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // capture read data and error in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      slverr_reg <= !addr_ok;
      if (rd_access) begin
        rdata_reg <= rdata_next;
      end
    end
  end
endmodule // svd_ctrl

// ---- rtl/svd_settle.v ----
// settle timer: output rises after the enable has stood for CYCLES clocks
// assumes one clock pclk; a low enable restarts the count at once
module svd_settle #(
  parameter CYCLES = 200,
  parameter CW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire run,
  output wire done
);
  reg [CW-1:0] count_reg;
  reg done_reg;

  // count up while running, hold at the end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {CW{1'b0}};
      done_reg <= 1'b0;
    end else if (!run) begin
      count_reg <= {CW{1'b0}};
      done_reg <= 1'b0;
    end else if (count_reg == CYCLES[CW-1:0] - 1'b1) begin
      done_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign done = done_reg;
endmodule // svd_settle

// ---- rtl/svd_sync.v ----
// two flip-flop synchroniser for asynchronous level inputs
// assumes one clock pclk and an active-low asynchronous reset
module svd_sync #(
  parameter WIDTH = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // first stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule // svd_sync

// ---- tb/svd_cmp_model.sv ----
// comparator and reference model facing the detector outputs of svd_ctrl
// assumes the bench sets supply and sense levels as 8-bit codes
module svd_cmp_model (
  input wire pclk,
  input wire detector_power,
  input wire [3:0] trip_level_select,
  input wire external_sense_select,
  input wire [7:0] supply_lvl,
  input wire [7:0] sense_lvl,
  output logic cmp_above,
  output logic cmp_below
);
  timeunit 1ns;
  timeprecision 1ps;
  // level under test and its trip point
  wire [7:0] lvl = external_sense_select ? sense_lvl : supply_lvl;
  wire [7:0] thr = {trip_level_select, 4'h0};
  initial cmp_above = 1'b0;
  initial cmp_below = 1'b1;
  // unpowered outputs flip every cycle so nothing stale looks valid
  always @(posedge pclk) begin
    cmp_above <= detector_power ? lvl >= thr : ~cmp_above;
    cmp_below <= detector_power ? lvl <= thr : ~cmp_below;
  end
endmodule // svd_cmp_model

// ---- tb/svd_ctrl_props.sv ----
// checker for svd_ctrl: port relations of the apb slave and detector outputs
// assumes a bind to every svd_ctrl instance; sees only its ports
module svd_ctrl_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cpu_idle,
  input wire detector_power,
  input wire [3:0] trip_level_select,
  input wire external_sense_select,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire wr_now = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup cycle of a control read, then its access cycle
  sequence ctl_rd_s;
    psel && !penable && !pwrite && paddr == 12'h000 ##1 psel && penable;
  endsequence
  // ------------------------------------
  // assertions
  // ------------------------------------
  zero_wait_a: assert property (pready)
    else $error("slave inserted a wait");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  ext_select_a: assert property (external_sense_select == (trip_level_select == 4'hF))
    else $error("external select disagrees with level");
  level_hold_a: assert property ($changed(trip_level_select) |-> $past(wr_now))
    else $error("level changed without a write");
  power_cause_a: assert property ($changed(detector_power) |-> $past(wr_now) || $changed(cpu_idle))
    else $error("power changed without cause");
  ctl_zero_a: assert property (ctl_rd_s |-> (prdata & 32'hFFFF5F10) == 32'h0)
    else $error("unused control bit read as one");
  ref_order_a: assert property (ctl_rd_s |-> !prdata[5] || prdata[6])
    else $error("reference stable before band gap");
  irq_sticky_a: assert property ($fell(irq) |-> $past(wr_now))
    else $error("interrupt dropped without a write");
endmodule // svd_ctrl_props
bind svd_ctrl svd_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_idle(cpu_idle), .detector_power(detector_power),
  .trip_level_select(trip_level_select), .external_sense_select(external_sense_select),
  .irq(irq));

// ---- tb/test_supply_voltage_detect_ctrl.sv ----
// bench for svd_ctrl: apb driver, queued read checks, detector scenarios
// assumes svd_cmp_model on the comparator side and the bound checker
module test_supply_voltage_detect_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_idle = 0, dir, cond;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, d;
  logic [7:0] supply_lvl = 8'h00, sense_lvl = 8'h00, lvl;
  wire [31:0] prdata;
  wire [3:0] tls;
  wire pready, pslverr, cmp_above, cmp_below, dpwr, ext_sel, irq;
  logic [32:0] exp_q[$];
  integer error_cnt = 0, total_checks = 0, seed = 36037, i;
  initial forever #5 pclk = ~pclk;
  // identification value is arbitrary, chosen apart from the default to prove the override
  svd_ctrl #(.BG_CYCLES(4), .REF_CYCLES(6), .INFO_ID(16'hC3A5)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .cmp_above(cmp_above),
    .cmp_below(cmp_below), .detector_power(dpwr), .trip_level_select(tls),
    .external_sense_select(ext_sel), .irq(irq));
  svd_cmp_model u_cmp (.pclk(pclk), .detector_power(dpwr), .trip_level_select(tls),
    .external_sense_select(ext_sel), .supply_lvl(supply_lvl), .sense_lvl(sense_lvl),
    .cmp_above(cmp_above), .cmp_below(cmp_below));
  // ------------------------------------
  // tasks
  // ------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // one transfer; request held until pready is seen high at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read result: error flag and data compared together
  task chk_rd(input logic err, input logic [31:0] got, input logic [32:0] want);
    chk({31'h0, err}, {31'h0, want[32]});
    chk(got, want[31:0]);
  endtask
  // note holds the expected error flag (unmapped offset) above the expected data
  task rd(input logic [11:0] a, input logic [31:0] want);
    exp_q.push_back({(a != 12'h000) && (a != 12'h004) && (a != 12'h008) && (a != 12'h00C),
                     want});
    apb(1'b0, a, 32'h0);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // read data compared as it completes, oldest note first
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) chk_rd(pslverr, prdata, exp_q.pop_front());
  // watchdog at 10000 cycles, well beyond the roughly 1800 cycles needed
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
  // ------------------------------------
  // scenarios
  // ------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h010, 32'h0);
    d = $random(seed) & 32'hFFFF7FFF;
    apb(1'b1, 12'h000, d);
    rd(12'h000, d & 32'h0000208F);
    apb(1'b1, 12'h002, 32'hFFFF); // unmapped write must be dropped
    rd(12'h000, d & 32'h0000208F);
    rd(12'h00C, 32'h0000C3A5);
    $display("test registers done");
    // every level code in both directions
    for (i = 0; i < 32; i++) begin
      dir = i[4];
      d = $random(seed);
      supply_lvl <= d[7:0];
      sense_lvl <= d[15:8];
      lvl = (i[3:0] == 4'hF) ? d[15:8] : d[7:0];
      cond = dir ? lvl >= {i[3:0], 4'h0} : lvl <= {i[3:0], 4'h0};
      apb(1'b1, 12'h000, {16'h0, 8'h80, dir, 3'h0, i[3:0]});
      repeat (20) @(posedge pclk);
      rd(12'h000, {16'h0, 8'h80, dir, 3'b110, i[3:0]});
      apb(1'b1, 12'h008, 32'h1);
      repeat (2) @(negedge pclk);
      chk({31'h0, irq}, {31'h0, cond});
      rd(12'h008, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      repeat (5) @(posedge pclk);
      rd(12'h004, {30'h0, 1'b1, cond});
      apb(1'b1, 12'h004, 32'h3);
      rd(12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h0);
    end
    $display("test trip events done");
    cpu_idle <= 1'b1;
    supply_lvl <= 8'h40;
    apb(1'b1, 12'h000, 32'hA000);
    @(negedge pclk);
    chk({31'h0, dpwr}, 32'h0);
    repeat (20) @(posedge pclk);
    rd(12'h000, 32'hA000);
    apb(1'b1, 12'h000, 32'h8000);
    @(negedge pclk);
    chk({31'h0, dpwr}, 32'h1);
    @(posedge pclk);
    cpu_idle <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(12'h000, 32'h8060);
    rd(12'h004, 32'h2);
    apb(1'b1, 12'h008, 32'h2);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    $display("test idle done");
    // reset in mid-run clears registers, timers and the interrupt
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
    $display("test reset done");
    end_sim;
  end
endmodule // test_supply_voltage_detect_ctrl
